// *** eight_bit_timer.sv ***
// Eight-bit timer count path with an AXI4-Lite register slave.
// ==========================================================
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module eight_bit_timer (
  input wire logic clock, // 10 MHz system clock.
  input wire logic reset, // Synchronous reset, active high.
  input wire logic awvalid, // Write address valid.
  output logic awready, // Write address ready.
  input wire logic [timer_pkg::ADDR_W-1:0] awaddr, // Write byte address.
  input wire logic wvalid, // Write data valid.
  output logic wready, // Write data ready.
  input wire logic [31:0] wdata, // Write data.
  input wire logic [3:0] wstrb, // Write byte strobes.
  output logic bvalid, // Write response valid.
  input wire logic bready, // Write response ready.
  output logic [1:0] bresp, // Write response code.
  input wire logic arvalid, // Read address valid.
  output logic arready, // Read address ready.
  input wire logic [timer_pkg::ADDR_W-1:0] araddr, // Read byte address.
  output logic rvalid, // Read data valid.
  input wire logic rready, // Read data ready.
  output logic [31:0] rdata, // Read data.
  output logic [1:0] rresp, // Read response code.
  input wire logic external_count_input, // Count pin, asynchronous.
  input wire logic watchdog_tick, // Watchdog time base pulse.
  input wire logic watchdog_clear, // Watchdog clear pulse.
  output logic watchdog_prescaled_tick, // Divided watchdog pulse.
  output logic second_timer_gate, // One-cycle pulse on each wrap.
  output logic counter_overflow_flag // Sticky overflow flag.
);
  import timer_pkg::*;

  // ==========================================================
  // State
  // ==========================================================
  quarter_t phase, next_phase; // Quarter phase of the instruction cycle.
  logic pin_meta, pin_sync; // Two-stage synchroniser for the pin.
  logic level_prev, next_level_prev; // Previous synchronised pin level.
  logic samp_a, next_samp_a; // Prescaler bit or corrected pin level, caught on Q2.
  logic samp_b, next_samp_b; // Copy of the Q2 sample caught on Q4.
  logic [7:0] eight_bit_count_register, next_count; // The count itself.
  logic [1:0] hold, next_hold; // Instruction cycles still held off.
  logic [5:0] option, next_option; // Source, edge, assignment and rate.
  logic next_flag, next_gate; // Next flag and gate pulse.
  logic aw_taken, next_aw_taken, w_taken, next_w_taken; // Write halves held.
  logic [ADDR_W-1:0] waddr, next_waddr; // Held write address.
  logic [31:0] wdata_q, next_wdata_q; // Held write data.
  logic [3:0] wstrb_q, next_wstrb_q; // Held write strobes.
  logic next_bvalid, next_rvalid; // Next response valids.
  logic [1:0] next_bresp, next_rresp; // Next response codes.
  logic [31:0] next_rdata; // Next read data.
  logic next_awready, next_wready, next_arready; // Next ready levels.

  // ==========================================================
  // Combinational helpers
  // ==========================================================
  logic tick; // Instruction cycle pulse on Q4.
  logic count_source_select, source_edge_select, to_watchdog; // Option fields.
  logic level, edge_pulse; // Corrected pin level and its counted edge.
  logic timer_level, sample_src, sync_event, count_event; // Count path.
  logic do_write, count_write, flag_clear, wrap, presc_clear; // Write effects.
  reg_sel_t wsel, rsel; // Decoded register selects.

  // Holds the shared prescaler.
  shared_prescaler #(.WIDTH(8)) prescaler (
    .clock(clock),
    .reset(reset),
    .rate(option[RATE_W-1:0]),
    .to_watchdog(to_watchdog),
    .count_pulse(count_source_select ? edge_pulse : tick),
    .watchdog_pulse(watchdog_tick),
    .clear(presc_clear),
    .timer_level(timer_level),
    .watchdog_out(watchdog_prescaled_tick)
  );

  // Computes the next value of every register in the block except the two pin synchroniser stages.
  always_comb begin
    count_source_select = option[OPT_SRC_BIT];
    source_edge_select = option[OPT_EDGE_BIT];
    to_watchdog = option[OPT_PSA_BIT];
    tick = (phase == Q4);
    next_phase = quarter_t'(2'(phase + 2'h1));
    // Inverting for edge select one turns falling edges into rising ones.
    level = pin_sync ^ source_edge_select;
    // The history holds the raw pin, so flipping the edge select fakes no edge.
    edge_pulse = level && !(level_prev ^ source_edge_select);
    next_level_prev = pin_sync;
    // The source that the Q2/Q4 sampler watches.
    sample_src = to_watchdog ? (count_source_select && level) : timer_level;
    next_samp_a = (phase == Q2) ? sample_src : samp_a;
    next_samp_b = tick ? samp_a : samp_b;
    sync_event = tick && samp_a && !samp_b;
    // Unprescaled timer mode counts every instruction cycle directly.
    if (!count_source_select && to_watchdog) begin
      count_event = tick;
    end else begin
      count_event = sync_event;
    end
    // Bus write path: halves are taken in either order, then applied.
    do_write = aw_taken && w_taken && !bvalid;
    wsel = decode(waddr);
    count_write = do_write && (wsel == SEL_COUNT) && wstrb_q[0];
    flag_clear = do_write && (wsel == SEL_FLAG) && wstrb_q[0] && wdata_q[FLAG_BIT];
    next_aw_taken = aw_taken;
    next_w_taken = w_taken;
    next_waddr = waddr;
    next_wdata_q = wdata_q;
    next_wstrb_q = wstrb_q;
    next_bvalid = bvalid && !bready;
    next_bresp = bresp;
    if (awvalid && !aw_taken) begin
      next_aw_taken = 1'b1;
      next_waddr = awaddr;
    end
    if (wvalid && !w_taken) begin
      next_w_taken = 1'b1;
      next_wdata_q = wdata;
      next_wstrb_q = wstrb;
    end
    if (do_write) begin
      next_aw_taken = 1'b0;
      next_w_taken = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (wsel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
    end
    next_option = option;
    if (do_write && (wsel == SEL_OPTION) && wstrb_q[0]) begin
      next_option = wdata_q[5:0];
    end
    // Counter: a write wins over a count in the same cycle.
    wrap = 1'b0;
    next_count = eight_bit_count_register;
    next_hold = (tick && hold != 2'h0) ? 2'(hold - 2'h1) : hold;
    if (count_write) begin
      next_count = wdata_q[7:0];
      next_hold = HOLD_CYCLES;
    end else if (count_event && hold == 2'h0) begin
      next_count = 8'(eight_bit_count_register + 8'h01);
      wrap = (eight_bit_count_register == COUNT_TOP);
    end
    // Owner-specific clear of the prescaler count.
    presc_clear = to_watchdog ? watchdog_clear : count_write;
    // The set wins over a clear arriving in the same cycle.
    next_flag = wrap || (counter_overflow_flag && !flag_clear);
    next_gate = wrap;
    // Read path: one read in flight, answered the cycle after it is taken.
    rsel = decode(araddr);
    next_rvalid = rvalid && !rready;
    next_rdata = rdata;
    next_rresp = rresp;
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp = (rsel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
      unique case (rsel)
        SEL_COUNT: next_rdata = {24'h000000, eight_bit_count_register};
        SEL_OPTION: next_rdata = {26'h0000000, option};
        SEL_FLAG: next_rdata = {31'h00000000, counter_overflow_flag};
        SEL_NONE: next_rdata = 32'h00000000;
      endcase
    end
    // Readies are registered copies of what the next state will allow.
    next_awready = !next_aw_taken && !next_bvalid;
    next_wready = !next_w_taken && !next_bvalid;
    next_arready = !next_rvalid; // A read is accepted only with no answer pending.
  end

  // Registers all state; the synchroniser's first stage feeds only the second.
  always_ff @(posedge clock) begin
    if (reset) begin
      phase <= Q1;
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      level_prev <= 1'b0;
      samp_a <= 1'b1; // High, like an idle-low pin seen with falling edges.
      samp_b <= 1'b1; // Matching high, so no false count follows reset.
      eight_bit_count_register <= COUNT_RESET;
      hold <= 2'h0;
      option <= OPTION_RESET;
      counter_overflow_flag <= 1'b0;
      second_timer_gate <= 1'b0;
      aw_taken <= 1'b0;
      w_taken <= 1'b0;
      waddr <= '0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid <= 1'b0;
      awready <= 1'b1;
      wready <= 1'b1;
      arready <= 1'b1;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end else begin
      phase <= next_phase;
      pin_meta <= external_count_input;
      pin_sync <= pin_meta;
      level_prev <= next_level_prev;
      samp_a <= next_samp_a;
      samp_b <= next_samp_b;
      eight_bit_count_register <= next_count;
      hold <= next_hold;
      option <= next_option;
      counter_overflow_flag <= next_flag;
      second_timer_gate <= next_gate;
      aw_taken <= next_aw_taken;
      w_taken <= next_w_taken;
      waddr <= next_waddr;
      wdata_q <= next_wdata_q;
      wstrb_q <= next_wstrb_q;
      bvalid <= next_bvalid;
      awready <= next_awready;
      wready <= next_wready;
      arready <= next_arready;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  // A count write lands exactly the written byte.
  a_write_loads_count: assert property (count_write |=>
    eight_bit_count_register == $past(wdata_q[7:0]))
    else $error("Count write did not load the written byte.");

  // Unprescaled timer mode adds one per instruction cycle.
  a_timer_every_cycle: assert property (
    tick && !count_source_select && to_watchdog && hold == 2'h0 && !count_write
    |=> eight_bit_count_register == 8'($past(eight_bit_count_register) + 8'h01))
    else $error("Timer mode missed an instruction cycle increment.");

  // A write holds counting off through the next two ticks.
  a_write_hold: assert property (count_write |=> hold == HOLD_CYCLES ##0
    (!count_write && hold != 2'h0) [*4] |=> $stable(eight_bit_count_register))
    else $error("Count moved while held off after a write.");

  // Counter mode only moves on a sampled edge.
  a_counter_needs_edge: assert property (
    count_source_select && !sync_event && !count_write
    |=> $stable(eight_bit_count_register))
    else $error("Counter mode counted without a sampled edge.");

  // The counted edge matches the edge select bit.
  a_edge_polarity: assert property (edge_pulse |->
    pin_sync == !source_edge_select && $past(pin_sync) == source_edge_select)
    else $error("Counted edge has the wrong polarity.");

  // Count write resets the prescaler output when it is assigned here.
  a_presc_cleared: assert property (count_write && !to_watchdog |=>
    !timer_level)
    else $error("Prescaler was not cleared by a count write.");

  // A wrap sets the flag and pulses the gate output.
  a_wrap_flags: assert property (wrap |=>
    counter_overflow_flag && second_timer_gate ##1 !second_timer_gate || wrap)
    else $error("Wrap did not set the flag and pulse the gate.");

  // Only a software clear drops the flag.
  a_flag_sticky: assert property (counter_overflow_flag && !flag_clear |=>
    counter_overflow_flag)
    else $error("Overflow flag dropped without a software clear.");

  // The first sample only changes on the Q2 phase.
  a_sample_phase: assert property (phase != Q2 |=> $stable(samp_a))
    else $error("Prescaler output sampled outside Q2.");

  // Main scenarios.
  c_wrap: cover property (wrap);
  c_flag_clear: cover property (counter_overflow_flag ##1 flag_clear);
  c_counter_edge: cover property (count_source_select && sync_event && hold == 2'h0);

endmodule
`default_nettype wire

// *** pulse_source.sv ***
// Behavioural pulse source that stands on the external count input pin.
`timescale 1ns/1ps
`default_nettype none
module pulse_source (
  input wire logic clock, // System clock that paces the edges.
  output logic level // Level driven onto the count pin.
);
  // ==========================================================
  // Edge generator
  // ==========================================================
  // The pin idles low and is always driven, as a push-pull source would.
  initial begin
    level = 1'b0;
  end

  // Toggles the pin n times, holding each level for half clock cycles.
  task automatic toggle(input int n, input int half);
    repeat (n) begin
      level <= ~level;
      repeat (half) @(posedge clock);
    end
  endtask
endmodule
`default_nettype wire

// *** shared_prescaler.sv ***
// Eight-bit prescaler shared between the count path and the watchdog.
`timescale 1ns/1ps
`default_nettype none
module shared_prescaler #(
  parameter int WIDTH = 8 // Prescaler counter width.
) (
  input wire logic clock, // System clock.
  input wire logic reset, // Synchronous reset, active high.
  input wire logic [timer_pkg::RATE_W-1:0] rate, // Division rate select.
  input wire logic to_watchdog, // High when the watchdog owns the prescaler.
  input wire logic count_pulse, // Count events from the timer side.
  input wire logic watchdog_pulse, // Count events from the watchdog side.
  input wire logic clear, // Clears the internal count.
  output logic timer_level, // Selected counter bit for the timer side.
  output logic watchdog_out // One-cycle divided pulse for the watchdog.
);
  import timer_pkg::*;

  // The rate field must be able to pick every bit of the counter.
  if (WIDTH != (1 << RATE_W)) begin : g_bad_width
    $error("Prescaler width must equal two to the rate field width.");
  end

  logic [WIDTH-1:0] count; // Internal count, not visible to software.
  logic [WIDTH-1:0] next_count; // Next internal count.
  logic next_watchdog_out; // Next watchdog pulse.
  logic in_pulse; // Event from whichever side owns the prescaler.
  logic [WIDTH-1:0] mask; // Low bits that must be all ones for a watchdog pulse.

  // ==========================================================
  // Next-state logic
  // ==========================================================
  // Counts events from the owner and clears on request; clear beats counting.
  always_comb begin
    in_pulse = to_watchdog ? watchdog_pulse : count_pulse;
    mask = WIDTH'((WIDTH'(1) << rate) - WIDTH'(1));
    next_count = count;
    next_watchdog_out = 1'b0;
    if (clear) begin
      next_count = '0;
    end else if (in_pulse) begin
      next_count = WIDTH'(count + WIDTH'(1));
      // Watchdog rates run one step faster than timer rates, down to 1:1.
      next_watchdog_out = to_watchdog && ((count & mask) == mask);
    end
  end

  // Registers the prescaler state.
  always_ff @(posedge clock) begin
    if (reset) begin
      count <= '0;
      watchdog_out <= 1'b0;
    end else begin
      count <= next_count;
      watchdog_out <= next_watchdog_out;
    end
  end

  // The timer side sees bit rate, giving rates of 1:2 up to 1:256.
  assign timer_level = count[rate];

endmodule
`default_nettype wire

// *** tb.sv ***
// Self-checking testbench for the eight-bit timer count path.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import timer_pkg::*;
  // ==========================================================
  // Signals
  // ==========================================================
  typedef struct {logic [31:0] lo; logic [31:0] hi; logic [1:0] resp;} note_t;
  logic clock = 1'b0; // System clock.
  logic reset = 1'b1; // Synchronous reset.
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0; // Write side strobes.
  logic arvalid = 1'b0, rready = 1'b0; // Read side strobes.
  logic awready, wready, bvalid, arready, rvalid; // Slave handshakes.
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0; // Byte addresses.
  logic [31:0] wdata = '0; // Write data.
  logic [3:0] wstrb = '0; // Write strobes.
  logic [31:0] rdata; // Read data.
  logic [1:0] bresp, rresp; // Response codes.
  logic pin; // Count pin.
  logic wd_tick = 1'b0, wd_clear = 1'b0; // Watchdog side inputs.
  logic wd_out, gate, flag; // Pulse and flag outputs.
  int fail_count = 0; // Mismatches.
  int compares = 0; // Comparisons.
  int gate_n = 0, wd_n = 0, cyc = 0, n0; // Pulse counts and cycle count.
  logic [7:0] v; // Random value.
  note_t rq[$]; // Expected read answers.
  logic [1:0] bq[$]; // Expected write responses.

  eight_bit_timer eight_bit_timer_i (.clock(clock), .reset(reset), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .external_count_input(pin), .watchdog_tick(wd_tick),
    .watchdog_clear(wd_clear), .watchdog_prescaled_tick(wd_out),
    .second_timer_gate(gate), .counter_overflow_flag(flag));
  pulse_source pulse_source_i (.clock(clock), .level(pin));

  // ==========================================================
  // Clock, monitors and timeout
  // ==========================================================
  // Half period of 50 ns gives 10 MHz.
  always #50 clock = ~clock;

  // Counts pulses, takes the oldest note on each answer and cuts hangs short.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (gate === 1'b1) gate_n <= gate_n + 1;
    if (wd_out === 1'b1) wd_n <= wd_n + 1;
    if (rvalid === 1'b1 && rready === 1'b1) chk_read(rq.pop_front());
    if (bvalid === 1'b1 && bready === 1'b1) chk_resp(bq.pop_front());
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
  end

  // ==========================================================
  // Compare and bus tasks
  // ==========================================================
  // Reports one mismatch.
  task automatic fail(input string msg);
    fail_count++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask

  // Compares a read answer with its note; counts may sit in a range.
  task automatic chk_read(input note_t e);
    compares++;
    if ((rdata >= e.lo) !== 1'b1 || (rdata <= e.hi) !== 1'b1 || rresp !== e.resp) begin
      fail($sformatf("read %0h/%0d want %0h..%0h/%0d", rdata, rresp, e.lo, e.hi, e.resp));
    end
  endtask

  // Compares a write response code.
  task automatic chk_resp(input logic [1:0] want);
    compares++;
    if (bresp !== want) fail($sformatf("bresp %0d want %0d", bresp, want));
  endtask

  // Compares a pulse count.
  task automatic chk_cnt(input int got, input int want);
    compares++;
    if (got != want) fail($sformatf("pulses %0d want %0d", got, want));
  endtask

  // Compares the overflow flag pin; an unknown level never passes.
  task automatic chk_flag(input logic want);
    compares++;
    if (flag !== want) fail($sformatf("flag pin %b want %b", flag, want));
  endtask

  // One write; readies are read mid-cycle, where they hold their edge value.
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    logic ad, wd, bd;
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clock);
      ad = awvalid & awready;
      wd = wvalid & wready;
      bd = bvalid;
      @(posedge clock);
      if (ad) awvalid <= 1'b0;
      if (wd) wvalid <= 1'b0;
    end while (!bd);
    bready <= 1'b0;
    // One edge passes so that a following write never re-raises bready at once.
    @(posedge clock);
  endtask

  // One read whose answer must lie between lo and hi.
  task automatic rd(input logic [3:0] a, input logic [31:0] lo, input logic [31:0] hi,
                    input logic [1:0] r);
    logic ad, dv;
    rq.push_back('{lo, hi, r});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clock);
      ad = arvalid & arready;
      dv = rvalid;
      @(posedge clock);
      if (ad) arvalid <= 1'b0;
    end while (!dv);
    rready <= 1'b0;
    // One edge passes so that a following read never re-raises rready at once.
    @(posedge clock);
  endtask

  // Lets n rising edges pass.
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Raises one watchdog side input for a single cycle.
  task automatic wd_pulse(input bit clr);
    if (clr) wd_clear <= 1'b1;
    else wd_tick <= 1'b1;
    @(posedge clock);
    wd_clear <= 1'b0;
    wd_tick <= 1'b0;
    idle(3);
  endtask

  // Prints the end of one test.
  task automatic tend(input string name);
    $display("test %s done", name);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic test_done();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    void'($urandom(32'h7907FAEB));
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    rd(ADDR_COUNT, 32'h0, 32'h0, RESP_OKAY);
    rd(ADDR_OPTION, 32'h3F, 32'h3F, RESP_OKAY);
    rd(ADDR_FLAG, 32'h0, 32'h0, RESP_OKAY);
    tend("reset");
    // Reads straight after a write fall inside the two held-off cycles.
    wr(ADDR_OPTION, 32'h08, 4'h1, RESP_OKAY);
    repeat (4) begin
      v = 8'($urandom);
      wr(ADDR_COUNT, {24'h0, v}, 4'hF, RESP_OKAY);
      rd(ADDR_COUNT, {24'h0, v}, {24'h0, v}, RESP_OKAY);
    end
    tend("hold");
    // About 25 instruction cycles pass; two are lost to the hold, so F8h wraps.
    wr(ADDR_COUNT, 32'hF8, 4'h1, RESP_OKAY);
    idle(100);
    rd(ADDR_COUNT, 32'h0F, 32'h10, RESP_OKAY);
    rd(ADDR_FLAG, 32'h1, 32'h1, RESP_OKAY);
    chk_cnt(gate_n, 1);
    chk_flag(1'b1);
    wr(ADDR_COUNT, 32'h40, 4'h1, RESP_OKAY);
    rd(ADDR_FLAG, 32'h1, 32'h1, RESP_OKAY);
    wr(ADDR_FLAG, 32'h1, 4'h1, RESP_OKAY);
    rd(ADDR_FLAG, 32'h0, 32'h0, RESP_OKAY);
    chk_flag(1'b0);
    tend("overflow");
    // Prescaler at 1:2 in front of the timer halves the count rate.
    wr(ADDR_OPTION, 32'h00, 4'h1, RESP_OKAY);
    wr(ADDR_COUNT, 32'h00, 4'h1, RESP_OKAY);
    idle(200);
    rd(ADDR_COUNT, 32'h15, 32'h1A, RESP_OKAY);
    wr(ADDR_OPTION, 32'h0A, 4'h1, RESP_OKAY);
    wd_pulse(1'b1);
    n0 = wd_n;
    repeat (8) wd_pulse(1'b0);
    chk_cnt(wd_n - n0, 2);
    tend("prescaler");
    // Rising edges: five toggles from low give three rises.
    wr(ADDR_OPTION, 32'h28, 4'h1, RESP_OKAY);
    idle(12);
    wr(ADDR_COUNT, 32'h00, 4'h1, RESP_OKAY);
    idle(4);
    pulse_source_i.toggle(5, 8);
    idle(20);
    rd(ADDR_COUNT, 32'h3, 32'h3, RESP_OKAY);
    pulse_source_i.toggle(1, 8);
    idle(20);
    rd(ADDR_COUNT, 32'h3, 32'h3, RESP_OKAY);
    // Falling edges with a prompt source: five toggles from low give two falls.
    wr(ADDR_OPTION, 32'h38, 4'h1, RESP_OKAY);
    idle(12);
    wr(ADDR_COUNT, 32'h00, 4'h1, RESP_OKAY);
    idle(4);
    pulse_source_i.toggle(5, 5);
    idle(20);
    rd(ADDR_COUNT, 32'h2, 32'h2, RESP_OKAY);
    tend("counter");
    wr(ADDR_COUNT, 32'h55, 4'h0, RESP_OKAY);
    rd(ADDR_COUNT, 32'h2, 32'h2, RESP_OKAY);
    wr(4'hC, 32'h1, 4'hF, RESP_DECERR);
    rd(4'hC, 32'h0, 32'h0, RESP_DECERR);
    v = 8'($urandom);
    wr(ADDR_OPTION, {26'h0, v[5:0]}, 4'h1, RESP_OKAY);
    rd(ADDR_OPTION, {26'h0, v[5:0]}, {26'h0, v[5:0]}, RESP_OKAY);
    tend("access");
    idle(4);
    test_done();
  end
endmodule
`default_nettype wire

// *** timer_pkg.sv ***
// Shared constants, types and decode helper for the eight-bit timer count path.
package timer_pkg;

  // ==========================================================
  // Register map
  // ==========================================================
  localparam int ADDR_W = 4; // Byte address bits decoded by the bus slave.
  localparam logic [3:0] ADDR_COUNT = 4'h0; // Eight-bit count register.
  localparam logic [3:0] ADDR_OPTION = 4'h4; // Source, edge, assignment and rate bits.
  localparam logic [3:0] ADDR_FLAG = 4'h8; // Overflow flag, write one to clear.

  // ==========================================================
  // Field layout and reset values
  // ==========================================================
  localparam int OPT_SRC_BIT = 5; // Count source select.
  localparam int OPT_EDGE_BIT = 4; // Source edge select.
  localparam int OPT_PSA_BIT = 3; // Prescaler goes to the watchdog when set.
  localparam int RATE_W = 3; // Width of the prescaler rate field at bit 0.
  localparam int FLAG_BIT = 0; // Overflow flag position.
  localparam logic [5:0] OPTION_RESET = 6'h3F; // All option bits come up set.
  localparam logic [7:0] COUNT_RESET = 8'h00; // Count after reset.
  localparam logic [7:0] COUNT_TOP = 8'hFF; // Value that wraps to zero.

  // ==========================================================
  // Timing
  // ==========================================================
  localparam logic [1:0] HOLD_CYCLES = 2'h2; // Instruction cycles held off after a write.

  // ==========================================================
  // Bus answers
  // ==========================================================
  localparam logic [1:0] RESP_OKAY = 2'h0; // Normal access.
  localparam logic [1:0] RESP_DECERR = 2'h3; // Unmapped address.

  // Quarter phases of one instruction cycle.
  typedef enum logic [1:0] {Q1 = 2'b00, Q2 = 2'b01, Q3 = 2'b10, Q4 = 2'b11} quarter_t;

  // Register selected by an address.
  typedef enum logic [1:0] {
    SEL_COUNT = 2'b00,
    SEL_OPTION = 2'b01,
    SEL_FLAG = 2'b10,
    SEL_NONE = 2'b11
  } reg_sel_t;

  // Decodes a byte address into the register it selects.
  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
    case (addr)
      ADDR_COUNT: decode = SEL_COUNT;
      ADDR_OPTION: decode = SEL_OPTION;
      ADDR_FLAG: decode = SEL_FLAG;
      default: decode = SEL_NONE;
    endcase
  endfunction

endpackage
